// *** dv/efcf_partner.sv ***
// Counts converter starts and interrupt entries seen at the far side.
`timescale 1ns/10ps
`default_nettype none
module efcf_partner (
  input  wire logic       clock,  // System clock.
  input  wire logic       rst,    // Synchronous reset.
  input  wire logic       conv_a, // Start A pulse.
  input  wire logic       conv_b, // Start B pulse.
  input  wire logic       irq,    // Level interrupt.
  output logic      [7:0] n_a,    // Starts seen on A.
  output logic      [7:0] n_b,    // Starts seen on B.
  output logic      [7:0] n_irq   // Interrupt entries.
);
  logic irq_q;
  // Each high cycle is one start, so starts that follow closely count apart.
  always_ff @(posedge clock) begin
    if (rst) begin
      n_a   <= 8'h00;
      n_b   <= 8'h00;
      n_irq <= 8'h00;
      irq_q <= 1'b0;
    end else begin
      n_a   <= n_a + 8'(conv_a);
      n_b   <= n_b + 8'(conv_b);
      n_irq <= n_irq + 8'(irq & ~irq_q);
      irq_q <= irq;
    end
  end
endmodule
`default_nettype wire

// *** dv/efcf_top_test.sv ***
// Register level test of the event flag clear and force block.
`timescale 1ns/10ps
`default_nettype none
module efcf_top_test;
  logic clock, rst, avs_read, avs_write, avs_waitrequest;
  logic hw_irq_evt, hw_conv_a_evt, hw_conv_b_evt, irq_out;
  logic conv_start_a_out, conv_start_b_out;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, q;
  logic [3:0]  avs_byteenable;
  logic [7:0]  n_a, n_b, n_irq;
  int          n_errors, num_checks;
  efcf_top #(.ADDR_W(5)) dut (.clock(clock), .rst(rst),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .hw_irq_evt(hw_irq_evt), .hw_conv_a_evt(hw_conv_a_evt),
    .hw_conv_b_evt(hw_conv_b_evt), .conv_start_a_out(conv_start_a_out),
    .conv_start_b_out(conv_start_b_out), .irq_out(irq_out));
  efcf_partner far_end (.clock(clock), .rst(rst), .conv_a(conv_start_a_out),
    .conv_b(conv_start_b_out), .irq(irq_out), .n_a(n_a), .n_b(n_b),
    .n_irq(n_irq));
  task automatic finish_test;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a,
                     input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clock);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= w;
    avs_read      <= !w;
    do begin
      @(posedge clock);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (n >= 50) begin
      n_errors++;
      finish_test();
    end
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    acc(1'b1, a, d, q);
    repeat (3) @(posedge clock);
  endtask
  task automatic rd(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask
  task automatic outs(input logic [7:0] a, b, i, input logic irq);
    chk({n_a, n_b, n_irq, 7'h00, irq_out}, {a, b, i, 7'h00, irq});
  endtask
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    repeat (5000) @(posedge clock);
    n_errors++;
    finish_test();
  end
  initial begin
    {rst, avs_read, avs_write, hw_irq_evt, hw_conv_a_evt, hw_conv_b_evt} = 6'h20;
    avs_address    = 5'h00;
    avs_writedata  = 32'h0;
    avs_byteenable = 4'hf;
    repeat (5) @(posedge clock);
    rst <= 1'b0;
    foreach (q[i]) if (i < 5) rd(5'(i * 4 + (i == 4) * 8), 32'h0);
    wr(5'h14, 32'h0);
    wr(5'h00, 32'hd);
    wr(5'h08, 32'hd);
    acc(1'b0, 5'h10, 32'h0, q);
    wr(5'h14, 32'h1);
    wr(5'h0c, 32'h4);
    wr(5'h0c, 32'h4);
    wr(5'h0c, 32'h8);
    outs(8'h2, 8'h1, 8'h0, 1'b0);
    wr(5'h08, 32'hfff2);
    wr(5'h0c, 32'hfff2);
    avs_byteenable <= 4'he;
    wr(5'h08, 32'hd);
    avs_byteenable <= 4'hf;
    wr(5'h08, 32'h0);
    rd(5'h04, 32'hc);
    wr(5'h08, 32'h4);
    rd(5'h04, 32'h8);
    wr(5'h08, 32'h8);
    rd(5'h04, 32'h0);
    acc(1'b0, 5'h10, 32'h0, q);
    wr(5'h0c, 32'h1);
    outs(8'h2, 8'h1, 8'h1, 1'b1);
    wr(5'h14, 32'h0);
    outs(8'h2, 8'h1, 8'h1, 1'b0);
    rd(5'h10, 32'h1);
    wr(5'h14, 32'h1);
    outs(8'h2, 8'h1, 8'h1, 1'b0);
    wr(5'h0c, 32'h1);
    outs(8'h2, 8'h1, 8'h1, 1'b0);
    wr(5'h08, 32'h1);
    outs(8'h2, 8'h1, 8'h2, 1'b1);
    rd(5'h10, 32'h1);
    wr(5'h08, 32'h1);
    rd(5'h04, 32'h0);
    wr(5'h00, 32'h0);
    wr(5'h0c, 32'hd);
    outs(8'h2, 8'h1, 8'h2, 1'b0);
    rd(5'h04, 32'hd);
    wr(5'h00, 32'hd);
    wr(5'h08, 32'hd);
    hw_conv_a_evt <= 1'b1;
    hw_conv_b_evt <= 1'b1;
    hw_irq_evt    <= 1'b1;
    @(posedge clock);
    {hw_conv_a_evt, hw_conv_b_evt, hw_irq_evt} <= 3'h0;
    repeat (3) @(posedge clock);
    outs(8'h3, 8'h2, 8'h3, 1'b1);
    finish_test();
  end
endmodule
`default_nettype wire

// *** hw/efcf_flag_core.sv ***
// Flag latching, pulse generation and pending interrupt logic.
`timescale 1ns/10ps
`default_nettype none
module efcf_flag_core (
  input wire logic clock, // System clock.
  input wire logic rst,   // Synchronous reset, active high.
  efcf_evt_if.core ev     // Event strobes and flags.
);
  logic [3:0] flag_q, flag_d;
  logic       pend_q, pend_d;
  logic       irq_q, irq_d, a_q, a_d, b_q, b_d;
  logic       irq_ev, irq_fire;

  assign irq_ev   = ev.set_evt[efcf_pkg::BIT_IRQ] & ev.enable[efcf_pkg::BIT_IRQ];
  // Fire only when the flag is clear or being cleared this cycle.
  assign irq_fire = (irq_ev | pend_q) &
                    (~flag_q[efcf_pkg::BIT_IRQ] | ev.clr_evt[efcf_pkg::BIT_IRQ]);

  always_comb begin
    flag_d = (flag_q & ~ev.clr_evt) | ev.set_evt; // see R1 see R2 see R5 see R6
    flag_d[efcf_pkg::BIT_IRQ] = irq_fire |
      (flag_q[efcf_pkg::BIT_IRQ] & ~ev.clr_evt[efcf_pkg::BIT_IRQ]) |
      ev.set_evt[efcf_pkg::BIT_IRQ]; // see R3 see R7
    flag_d = flag_d & efcf_pkg::FLAG_MASK; // see R12
    // At most one event is held while the flag is set.
    pend_d = irq_fire ? (irq_ev & pend_q) : (pend_q | irq_ev); // see R10
    irq_d  = irq_fire;                                          // see R7
    a_d    = ev.set_evt[efcf_pkg::BIT_CONV_A] &
             ev.enable[efcf_pkg::BIT_CONV_A];                   // see R6 see R11
    b_d    = ev.set_evt[efcf_pkg::BIT_CONV_B] &
             ev.enable[efcf_pkg::BIT_CONV_B];                   // see R5 see R11
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      flag_q <= efcf_pkg::LATCH_RESET;
      pend_q <= 1'b0;
      irq_q  <= 1'b0;
      a_q    <= 1'b0;
      b_q    <= 1'b0;
    end else begin
      flag_q <= flag_d;
      pend_q <= pend_d;
      irq_q  <= irq_d;
      a_q    <= a_d;
      b_q    <= b_d;
    end
  end

  assign ev.flags     = flag_q;
  assign ev.irq_pulse = irq_q;
  assign ev.a_pulse   = a_q;
  assign ev.b_pulse   = b_q;

  a_irq_no_repeat: assert property (@(posedge clock) disable iff (rst) // see R10
    irq_q |-> !irq_fire || ev.clr_evt[efcf_pkg::BIT_IRQ])
    else $error("interrupt fired while flag set");
  a_a_pulse_set: assert property (@(posedge clock) disable iff (rst) // see R11
    a_q |-> flag_q[efcf_pkg::BIT_CONV_A])
    else $error("pulse A without flag");
endmodule
`default_nettype wire

// *** hw/efcf_top.sv ***
// Avalon-MM register slave with interrupt status around the flag core.
//
// The Avalon-MM interface to the registers and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1: A written 1 in bit 3 of the clear register drops the conversion start B flag.
// R2: A written 1 in bit 2 of the clear register drops the conversion start A flag.
// R3: A written 1 in bit 0 of the clear register drops the interrupt flag and re-arms interrupts.
// R4: Clear bits written 0 change nothing and every clear bit reads 0.
// R5: A written 1 in force bit 3 sets flag B and pulses output B only if B is enabled.
// R6: A written 1 in force bit 2 sets flag A and pulses output A only if A is enabled.
// R7: A written 1 in force bit 0 sets the interrupt flag and interrupts only if enabled.
// R8: Force bits written 0 are ignored and every force bit reads 0.
// R9: Software masks interrupts, sets up, clears stale flags, then unmasks.
// R10: No new interrupt while its flag is set, with one event held until cleared.
// R11: A conversion start pulse fires once per enabled set event, whether or not its flag is already set.
// R12: Reserved bits of clear and force read 0 and ignore writes.
module efcf_top #(
  parameter int unsigned ADDR_W = efcf_pkg::ADDR_W
) (
  input  wire logic              clock,            // System clock.
  input  wire logic              rst,              // Synchronous reset.
  input  wire logic [ADDR_W-1:0] avs_address,      // Byte address.
  input  wire logic              avs_read,         // Read request.
  input  wire logic              avs_write,        // Write request.
  input  wire logic [31:0]       avs_writedata,    // Write data.
  input  wire logic [3:0]        avs_byteenable,   // Byte enables.
  output logic      [31:0]       avs_readdata,     // Read data.
  output logic                   avs_waitrequest,  // Stall.
  input  wire logic              hw_irq_evt,       // Interrupt source event.
  input  wire logic              hw_conv_a_evt,    // Conversion A event.
  input  wire logic              hw_conv_b_evt,    // Conversion B event.
  output logic                   conv_start_a_out, // Conversion A pulse.
  output logic                   conv_start_b_out, // Conversion B pulse.
  output logic                   irq_out           // Level interrupt.
);
  efcf_evt_if ev ();
  logic [3:0]  sel_q, sel_d, stat_q, stat_d, mask_q, mask_d;
  logic [31:0] rd_q, rd_d;
  logic        ack_q, ack_d;
  logic        wr_go, rd_go, lo_en;
  logic [3:0]  clr_w, frc_w;
  logic [ADDR_W-1:0] ofs_stat, ofs_mask;

  // Status and mask sit after the four flag registers.
  assign ofs_stat = ADDR_W'(efcf_pkg::OFS_STATUS);
  assign ofs_mask = ADDR_W'(efcf_pkg::OFS_MASK);
  assign lo_en = avs_byteenable[0];
  assign wr_go = avs_write & ~ack_q;
  assign rd_go = avs_read & ~ack_q;
  assign clr_w = (wr_go && lo_en && avs_address == efcf_pkg::OFS_CLEAR) ?
                 (avs_writedata[3:0] & efcf_pkg::FLAG_MASK) : 4'h0; // see R4 see R12
  assign frc_w = (wr_go && lo_en && avs_address == efcf_pkg::OFS_FORCE) ?
                 (avs_writedata[3:0] & efcf_pkg::FLAG_MASK) : 4'h0; // see R8 see R12

  assign ev.clr_evt = clr_w; // see R1 see R2 see R3
  assign ev.set_evt = frc_w |
    {hw_conv_b_evt, hw_conv_a_evt, 1'b0, hw_irq_evt};             // see R5 see R6 see R7
  assign ev.enable  = sel_q;

  efcf_flag_core u_core (
    .clock (clock),
    .rst   (rst),
    .ev    (ev)
  );

  always_comb begin
    sel_d  = sel_q;
    mask_d = mask_q;
    stat_d = stat_q;
    rd_d   = rd_q;
    ack_d  = (avs_read | avs_write) & ~ack_q;
    if (wr_go && lo_en && avs_address == efcf_pkg::OFS_SELECT) begin
      sel_d = avs_writedata[3:0] & efcf_pkg::FLAG_MASK;
    end
    if (wr_go && lo_en && avs_address == ofs_mask) begin
      mask_d = avs_writedata[3:0] & efcf_pkg::FLAG_MASK;
    end
    if (rd_go) begin
      case (avs_address)
        efcf_pkg::OFS_SELECT: rd_d = {28'h0, sel_q};
        efcf_pkg::OFS_LATCH:  rd_d = {28'h0, ev.flags};
        efcf_pkg::OFS_CLEAR:  rd_d = 32'h0;                     // see R4
        efcf_pkg::OFS_FORCE:  rd_d = 32'h0;                     // see R8
        default: begin
          if (avs_address == ofs_stat) begin
            rd_d = {28'h0, stat_q};
          end else if (avs_address == ofs_mask) begin
            rd_d = {28'h0, mask_q};
          end else begin
            rd_d = efcf_pkg::UNMAPPED_VAL;
          end
        end
      endcase
    end
    // Read of status clears it, but a new event in the same cycle wins.
    if (rd_go && avs_address == ofs_stat) begin
      stat_d = 4'h0;
    end
    stat_d = stat_d | {ev.b_pulse, ev.a_pulse, 1'b0, ev.irq_pulse};
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      sel_q  <= efcf_pkg::SELECT_RESET;
      mask_q <= 4'h0;
      stat_q <= 4'h0;
      rd_q   <= 32'h0;
      ack_q  <= 1'b0;
    end else begin
      sel_q  <= sel_d;
      mask_q <= mask_d;
      stat_q <= stat_d;
      rd_q   <= rd_d;
      ack_q  <= ack_d;
    end
  end

  assign avs_waitrequest  = (avs_read | avs_write) & ~ack_q;
  assign avs_readdata     = rd_q;
  assign conv_start_a_out = ev.a_pulse;
  assign conv_start_b_out = ev.b_pulse;
  assign irq_out          = |(stat_q & mask_q);

  a_clear_drops: assert property (@(posedge clock) disable iff (rst) // see R2
    (clr_w[2] && !ev.set_evt[2]) |=> !ev.flags[2])
    else $error("clear A did not drop flag");
  a_clear_b_drops: assert property (@(posedge clock) disable iff (rst) // see R1
    (clr_w[3] && !ev.set_evt[3]) |=> !ev.flags[3])
    else $error("clear B did not drop flag");
  a_force_a_set: assert property (@(posedge clock) disable iff (rst) // see R6
    frc_w[2] |=> ev.flags[2] && (conv_start_a_out == $past(sel_q[2])))
    else $error("force A wrong");
  a_force_b_set: assert property (@(posedge clock) disable iff (rst) // see R5
    frc_w[3] |=> ev.flags[3] && (conv_start_b_out == $past(sel_q[3])))
    else $error("force B wrong");
  a_force_irq_set: assert property (@(posedge clock) disable iff (rst) // see R7
    frc_w[0] |=> ev.flags[0])
    else $error("force interrupt did not set flag");
  a_clr_reads_zero: assert property (@(posedge clock) disable iff (rst) // see R4
    (rd_go && avs_address == efcf_pkg::OFS_CLEAR) |=> avs_readdata == 32'h0)
    else $error("clear register read nonzero");
  a_frc_reads_zero: assert property (@(posedge clock) disable iff (rst) // see R8
    (rd_go && avs_address == efcf_pkg::OFS_FORCE) |=> avs_readdata == 32'h0)
    else $error("force register read nonzero");
  a_rsvd_flags_zero: assert property (@(posedge clock) disable iff (rst) // see R12
    ev.flags[1] == 1'b0)
    else $error("reserved flag set");
  a_irq_rearm: assert property (@(posedge clock) disable iff (rst) // see R3
    (clr_w[0] && !ev.set_evt[0]) |=> !ev.flags[0] || ev.irq_pulse)
    else $error("interrupt clear failed");
endmodule
`default_nettype wire

// *** shared/efcf_evt_if.sv ***
// Event strobes passed from the register slave to the flag core.
`timescale 1ns/10ps
`default_nettype none
interface efcf_evt_if;
  logic [3:0] set_evt;   // Hardware or forced set per flag.
  logic [3:0] clr_evt;   // Write-one clear per flag.
  logic [3:0] enable;    // Source enables.
  logic [3:0] flags;     // Latched flags.
  logic       irq_pulse; // Interrupt pulse.
  logic       a_pulse;   // Conversion start A pulse.
  logic       b_pulse;   // Conversion start B pulse.
  modport core (input set_evt, clr_evt, enable,
                output flags, irq_pulse, a_pulse, b_pulse);
  modport regs (output set_evt, clr_evt, enable,
                input flags, irq_pulse, a_pulse, b_pulse);
endinterface
`default_nettype wire

// *** shared/efcf_pkg.sv ***
// Constants shared by the event flag clear and force block.
package efcf_pkg;
  localparam int unsigned ADDR_W       = 5;
  localparam int unsigned DATA_W       = 32;
  localparam int unsigned REG_W        = 16;
  localparam logic [4:0]  OFS_SELECT   = 5'h00;
  localparam logic [4:0]  OFS_LATCH    = 5'h04;
  localparam logic [4:0]  OFS_CLEAR    = 5'h08;
  localparam logic [4:0]  OFS_FORCE    = 5'h0c;
  localparam logic [4:0]  OFS_STATUS   = 5'h10;
  localparam logic [4:0]  OFS_MASK     = 5'h14;
  localparam int unsigned BIT_IRQ      = 0;
  localparam int unsigned BIT_CONV_A   = 2;
  localparam int unsigned BIT_CONV_B   = 3;
  localparam logic [3:0]  FLAG_MASK    = 4'hd;
  localparam logic [3:0]  SELECT_RESET = 4'h0;
  localparam logic [3:0]  LATCH_RESET  = 4'h0;
  localparam logic [31:0] UNMAPPED_VAL = 32'h0000_0000;
endpackage
